// ==== verilog/sensor_smbus_pkg.sv ====
package sensor_smbus_pkg;

    // ****************
    // timing
    // ****************
    localparam int CORE_CLK_MHZ      = 100;
    localparam int TIMEOUT_MIN_US    = 25000;
    localparam int TIMEOUT_MAX_US    = 35000;
    // midpoint of the window keeps margin against clock tolerance both ways
    localparam int TIMEOUT_US        = 30000;
    localparam int TIMEOUT_CYCLES    = TIMEOUT_US * CORE_CLK_MHZ;
    localparam int TIMEOUT_MIN_CYC   = TIMEOUT_MIN_US * CORE_CLK_MHZ;
    localparam int TIMEOUT_MAX_CYC   = TIMEOUT_MAX_US * CORE_CLK_MHZ;

    // ****************
    // bus address (value is arbitrary)
    // ****************
    localparam logic [6:0] DEFAULT_SLAVE_ADDR = 7'h2A;

    // ****************
    // register offsets
    // ****************
    localparam logic [7:0] OFS_LOCAL_TEMPERATURE          = 8'h00;
    localparam logic [7:0] OFS_REMOTE_TEMPERATURE_HIGH    = 8'h01;
    localparam logic [7:0] OFS_ALARM_FLAGS                = 8'h02;
    localparam logic [7:0] OFS_CONFIGURATION              = 8'h03;
    localparam logic [7:0] OFS_CONVERSION_RATE            = 8'h04;
    localparam logic [7:0] OFS_LOCAL_UPPER_LIMIT          = 8'h05;
    localparam logic [7:0] OFS_UNUSED_06                  = 8'h06;
    localparam logic [7:0] OFS_REMOTE_UPPER_LIMIT_HIGH    = 8'h07;
    localparam logic [7:0] OFS_REMOTE_LOWER_LIMIT_HIGH    = 8'h08;
    localparam logic [7:0] OFS_CONFIGURATION_ALIAS        = 8'h09;
    localparam logic [7:0] OFS_CONVERSION_RATE_ALIAS      = 8'h0A;
    localparam logic [7:0] OFS_LOCAL_UPPER_LIMIT_ALIAS    = 8'h0B;
    localparam logic [7:0] OFS_UNUSED_0C                  = 8'h0C;
    localparam logic [7:0] OFS_REMOTE_UPPER_LIMIT_ALIAS   = 8'h0D;
    localparam logic [7:0] OFS_REMOTE_LOWER_LIMIT_ALIAS   = 8'h0E;
    localparam logic [7:0] OFS_SINGLE_CONVERSION_TRIGGER  = 8'h0F;
    localparam logic [7:0] OFS_REMOTE_TEMPERATURE_LOW     = 8'h10;
    localparam logic [7:0] OFS_REMOTE_OFFSET_HIGH         = 8'h11;

    // ****************
    // reset values and field masks
    // ****************
    localparam logic [7:0] RST_CONFIGURATION              = 8'h00;
    localparam logic [7:0] RST_CONVERSION_RATE            = 8'h08;
    localparam logic [7:0] RST_LOCAL_UPPER_LIMIT          = 8'h46;
    localparam logic [7:0] RST_REMOTE_UPPER_LIMIT_HIGH    = 8'h69;
    localparam logic [7:0] RST_REMOTE_LOWER_LIMIT_HIGH    = 8'h00;
    localparam logic [7:0] RST_REMOTE_OFFSET_HIGH         = 8'h00;
    localparam logic [7:0] READ_AS_ZERO                   = 8'h00;
    // fine: bits 7..3 carry 1/2 .. 1/32, coarse: bits 4..3 forced low
    localparam logic [7:0] LSB_MASK_FINE                  = 8'hF8;
    localparam logic [7:0] LSB_MASK_COARSE                = 8'hE0;
    localparam logic [2:0] LAST_BIT                       = 3'h7;

    // ****************
    // types
    // ****************
    typedef struct packed {
        logic [7:0] local_temperature;
        logic [7:0] remote_temperature_high_byte;
        logic [7:0] remote_temperature_low_byte;
        logic [7:0] alarm_flags;
        logic       filter_on;
        logic       remote_lsb_extend_enable;
    } meas_type;

    typedef struct packed {
        logic [7:0] configuration;
        logic [7:0] conversion_rate;
        logic [7:0] local_upper_limit;
        logic [7:0] remote_upper_limit_high_byte;
        logic [7:0] remote_lower_limit_high_byte;
        logic [7:0] remote_offset_high_byte;
    } cfg_type;

    localparam cfg_type CFG_RESET = '{
        configuration:                RST_CONFIGURATION,
        conversion_rate:              RST_CONVERSION_RATE,
        local_upper_limit:            RST_LOCAL_UPPER_LIMIT,
        remote_upper_limit_high_byte: RST_REMOTE_UPPER_LIMIT_HIGH,
        remote_lower_limit_high_byte: RST_REMOTE_LOWER_LIMIT_HIGH,
        remote_offset_high_byte:      RST_REMOTE_OFFSET_HIGH
    };

    // s[0] first flop, s[2] third; f is the agreed value
    typedef struct packed {
        logic [2:0] s;
        logic       f;
    } sync_type;

    localparam sync_type SYNC_LOW  = 4'h0;
    localparam sync_type SYNC_HIGH = 4'hF;

    typedef enum logic [3:0] {
        SMB_IDLE, SMB_ADDR, SMB_ADDR_ACK, SMB_CMD, SMB_CMD_ACK,
        SMB_WDATA, SMB_WDATA_ACK, SMB_RDATA, SMB_RACK, SMB_IGNORE
    } smb_state_type;

    function automatic sync_type sync_step(sync_type cur, logic in_bit);
        sync_type nxt;
        nxt.s = {cur.s[1], cur.s[0], in_bit};
        nxt.f = (cur.s[1] == cur.s[2]) ? cur.s[2] : cur.f;
        return nxt;
    endfunction

endpackage

// ==== verilog/sensor_smbus_register_front.sv ====
// Summary of operation
// - with the bus held low too long, the serial state machine returns to idle
// - bus timeout fires after 25 ms and no later than 35 ms of low level
// - a start condition anywhere abandons the transfer and restarts decoding
// - the byte after any start is taken as the bus address byte
// - addresses 09, 0A, 0B, 0D, 0E reach the same storage as 03, 04, 05, 07, 08
// - any write to 0F starts one conversion; nothing stored, reads back zero
// - remote low byte: fine fraction bits 7..3 when filtered or extended, else bits 4..3 zero
// - a write is address, command and one data byte, most significant bit first
// - at the end of a read either acknowledge or not-acknowledge is accepted
module sensor_smbus_register_front
    import sensor_smbus_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR        = DEFAULT_SLAVE_ADDR,
    parameter int         TIMEOUT_CYC       = TIMEOUT_CYCLES
) (
    input  wire logic     i_core_clk,        // core clock, 100 MHz
    input  wire logic     i_rst_n,           // async reset, active low
    input  wire logic     i_link_clk,        // free-running bus sampling clock
    input  wire logic     i_scl,             // bus clock pin
    input  wire logic     i_sda,             // bus data pin, input side
    output logic          o_sda,             // bus data pin, output side (always low)
    output logic          o_sda_oe_n,        // bus data drive enable, low drives
    input  wire meas_type i_meas,            // measured values, core domain
    output cfg_type       o_cfg,             // settings, link domain
    output logic          o_conv_start,      // one-cycle conversion start, core domain
    output logic          o_bus_timeout      // one-cycle timeout pulse, core domain
);

    // ****************
    // elaboration checks
    // ****************
    localparam int CNT_W = $clog2(TIMEOUT_CYC + 1);

    if (TIMEOUT_CYC < 2) begin : g_bad_timeout
        $error("timeout count must be at least two cycles");
    end

    // ****************
    // state types
    // ****************
    typedef struct packed {
        sync_type          scl;
        sync_type          sda;
        logic [CNT_W-1:0]  low_cnt;
        logic              to_tgl;
        logic              to_pulse;
        sync_type          os;
        logic              conv_start;
        sync_type          ack;
        logic              req_tgl;
        meas_type          snap;
    } core_state_type;

    typedef struct packed {
        sync_type          scl;
        sync_type          sda;
        sync_type          to;
        sync_type          req;
        logic              ack_tgl;
        meas_type          meas;
        cfg_type           cfg;
        smb_state_type     st;
        logic [7:0]        shift;
        logic [2:0]        cnt;
        logic              full;
        logic              rw;
        logic              host_ack;
        logic [7:0]        ptr;
        logic              sda_drv;
        logic              os_tgl;
    } link_state_type;

    core_state_type c_q;
    core_state_type c_d;
    link_state_type l_q;
    link_state_type l_d;

    // ****************
    // register map helpers
    // ****************
    function automatic logic [7:0] alias_target(logic [7:0] ofs);
        logic [7:0] res;
        res = ofs;
        unique case (ofs)
            OFS_CONFIGURATION_ALIAS:      res = OFS_CONFIGURATION;
            OFS_CONVERSION_RATE_ALIAS:    res = OFS_CONVERSION_RATE;
            OFS_LOCAL_UPPER_LIMIT_ALIAS:  res = OFS_LOCAL_UPPER_LIMIT;
            OFS_REMOTE_UPPER_LIMIT_ALIAS: res = OFS_REMOTE_UPPER_LIMIT_HIGH;
            OFS_REMOTE_LOWER_LIMIT_ALIAS: res = OFS_REMOTE_LOWER_LIMIT_HIGH;
            default:                      res = ofs;
        endcase
        return res;
    endfunction

    function automatic logic [7:0] read_reg(link_state_type s);
        logic [7:0] res;
        logic       fine;
        fine = s.meas.filter_on | s.meas.remote_lsb_extend_enable;
        unique case (alias_target(s.ptr))
            OFS_LOCAL_TEMPERATURE:       res = s.meas.local_temperature;
            OFS_REMOTE_TEMPERATURE_HIGH: res = s.meas.remote_temperature_high_byte;
            OFS_ALARM_FLAGS:             res = s.meas.alarm_flags;
            OFS_CONFIGURATION:           res = s.cfg.configuration;
            OFS_CONVERSION_RATE:         res = s.cfg.conversion_rate;
            OFS_LOCAL_UPPER_LIMIT:       res = s.cfg.local_upper_limit;
            OFS_REMOTE_UPPER_LIMIT_HIGH: res = s.cfg.remote_upper_limit_high_byte;
            OFS_REMOTE_LOWER_LIMIT_HIGH: res = s.cfg.remote_lower_limit_high_byte;
            OFS_REMOTE_TEMPERATURE_LOW:  res = s.meas.remote_temperature_low_byte
                                               & (fine ? LSB_MASK_FINE : LSB_MASK_COARSE);
            OFS_REMOTE_OFFSET_HIGH:      res = s.cfg.remote_offset_high_byte;
            // trigger location, unused and unmapped locations read as zero
            default:                     res = READ_AS_ZERO;
        endcase
        return res;
    endfunction

    // ****************
    // core domain: timeout timer, conversion start, value snapshot
    // ****************
    always_comb begin
        c_d            = c_q;
        c_d.scl        = sync_step(c_q.scl, i_scl);
        c_d.sda        = sync_step(c_q.sda, i_sda);
        c_d.os         = sync_step(c_q.os, l_q.os_tgl);
        c_d.ack        = sync_step(c_q.ack, l_q.ack_tgl);
        c_d.to_pulse   = 1'b0;

        // low time on either line is counted; both high clears it
        if (c_q.scl.f && c_q.sda.f) begin
            c_d.low_cnt = '0;
        end else if (c_q.low_cnt != CNT_W'(TIMEOUT_CYC)) begin
            c_d.low_cnt = c_q.low_cnt + CNT_W'(1);
            if (c_q.low_cnt == CNT_W'(TIMEOUT_CYC - 1)) begin
                // fires once per low period, inside the 25..35 ms window
                c_d.to_tgl   = ~c_q.to_tgl;
                c_d.to_pulse = 1'b1;
            end
        end

        c_d.conv_start = (c_d.os.f != c_q.os.f);

        // a new snapshot only once the link side took the previous one,
        // so the words it copies never change under it
        if (c_q.ack.f == c_q.req_tgl) begin
            c_d.snap    = i_meas;
            c_d.req_tgl = ~c_q.req_tgl;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            c_q     <= '0;
            c_q.scl <= SYNC_HIGH;
            c_q.sda <= SYNC_HIGH;
        end else begin
            c_q <= c_d;
        end
    end

    // ****************
    // link domain: bus engine and register storage
    // ****************
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic to_evt;

    always_comb begin
        l_d     = l_q;
        l_d.scl = sync_step(l_q.scl, i_scl);
        l_d.sda = sync_step(l_q.sda, i_sda);
        l_d.to  = sync_step(l_q.to, c_q.to_tgl);
        l_d.req = sync_step(l_q.req, c_q.req_tgl);

        scl_rise   = l_d.scl.f & ~l_q.scl.f;
        scl_fall   = ~l_d.scl.f & l_q.scl.f;
        start_cond = ~l_d.sda.f & l_q.sda.f & l_q.scl.f & l_d.scl.f;
        stop_cond  = l_d.sda.f & ~l_q.sda.f & l_q.scl.f & l_d.scl.f;
        to_evt     = (l_d.to.f != l_q.to.f);

        if (l_d.req.f != l_q.req.f) begin
            l_d.meas    = c_q.snap;
            l_d.ack_tgl = ~l_q.ack_tgl;
        end

        if (to_evt) begin
            l_d.st      = SMB_IDLE;
            l_d.sda_drv = 1'b0;
            l_d.full    = 1'b0;
        end else if (start_cond) begin
            // repeated start is legal in any state, even mid-byte
            l_d.st      = SMB_ADDR;
            l_d.cnt     = '0;
            l_d.full    = 1'b0;
            l_d.sda_drv = 1'b0;
        end else if (stop_cond) begin
            l_d.st      = SMB_IDLE;
            l_d.sda_drv = 1'b0;
            l_d.full    = 1'b0;
        end else begin
            unique case (l_q.st)
                SMB_IDLE, SMB_IGNORE: begin
                    l_d.sda_drv = 1'b0;
                end
                SMB_ADDR, SMB_CMD, SMB_WDATA: begin
                    if (scl_rise) begin
                        // most significant bit arrives first
                        l_d.shift = {l_q.shift[6:0], l_q.sda.f};
                        l_d.cnt   = l_q.cnt + 3'h1;
                        l_d.full  = (l_q.cnt == LAST_BIT);
                    end else if (scl_fall && l_q.full) begin
                        l_d.full = 1'b0;
                        l_d.cnt  = '0;
                        unique case (l_q.st)
                            SMB_ADDR: begin
                                if (l_q.shift[7:1] == SLAVE_ADDR) begin
                                    l_d.rw      = l_q.shift[0];
                                    l_d.st      = SMB_ADDR_ACK;
                                    l_d.sda_drv = 1'b1;
                                end else begin
                                    l_d.st = SMB_IGNORE;
                                end
                            end
                            SMB_CMD: begin
                                l_d.ptr     = l_q.shift;
                                l_d.st      = SMB_CMD_ACK;
                                l_d.sda_drv = 1'b1;
                            end
                            default: begin
                                unique case (alias_target(l_q.ptr))
                                    OFS_CONFIGURATION:
                                        l_d.cfg.configuration = l_q.shift;
                                    OFS_CONVERSION_RATE:
                                        l_d.cfg.conversion_rate = l_q.shift;
                                    OFS_LOCAL_UPPER_LIMIT:
                                        l_d.cfg.local_upper_limit = l_q.shift;
                                    OFS_REMOTE_UPPER_LIMIT_HIGH:
                                        l_d.cfg.remote_upper_limit_high_byte = l_q.shift;
                                    OFS_REMOTE_LOWER_LIMIT_HIGH:
                                        l_d.cfg.remote_lower_limit_high_byte = l_q.shift;
                                    OFS_REMOTE_OFFSET_HIGH:
                                        l_d.cfg.remote_offset_high_byte = l_q.shift;
                                    OFS_SINGLE_CONVERSION_TRIGGER:
                                        l_d.os_tgl = ~l_q.os_tgl;
                                    default: ;
                                endcase
                                l_d.st      = SMB_WDATA_ACK;
                                l_d.sda_drv = 1'b1;
                            end
                        endcase
                    end
                end
                SMB_ADDR_ACK: begin
                    if (scl_fall) begin
                        l_d.cnt  = '0;
                        l_d.full = 1'b0;
                        if (l_q.rw) begin
                            l_d.shift   = read_reg(l_q);
                            l_d.sda_drv = ~l_d.shift[7];
                            l_d.st      = SMB_RDATA;
                        end else begin
                            l_d.sda_drv = 1'b0;
                            l_d.st      = SMB_CMD;
                        end
                    end
                end
                SMB_CMD_ACK: begin
                    if (scl_fall) begin
                        l_d.sda_drv = 1'b0;
                        l_d.st      = SMB_WDATA;
                    end
                end
                SMB_WDATA_ACK: begin
                    if (scl_fall) begin
                        // exactly one data byte; further bytes get no acknowledge
                        l_d.sda_drv = 1'b0;
                        l_d.st      = SMB_IGNORE;
                    end
                end
                SMB_RDATA: begin
                    if (scl_rise) begin
                        l_d.cnt  = l_q.cnt + 3'h1;
                        l_d.full = (l_q.cnt == LAST_BIT);
                    end else if (scl_fall) begin
                        if (l_q.full) begin
                            l_d.full    = 1'b0;
                            l_d.cnt     = '0;
                            l_d.sda_drv = 1'b0;
                            l_d.st      = SMB_RACK;
                        end else begin
                            l_d.shift   = {l_q.shift[6:0], 1'b0};
                            l_d.sda_drv = ~l_d.shift[7];
                        end
                    end
                end
                SMB_RACK: begin
                    if (scl_rise) begin
                        l_d.host_ack = ~l_q.sda.f;
                    end else if (scl_fall) begin
                        if (l_q.host_ack) begin
                            // no auto-increment: the same register is sent again
                            l_d.shift   = read_reg(l_q);
                            l_d.sda_drv = ~l_d.shift[7];
                            l_d.st      = SMB_RDATA;
                        end else begin
                            l_d.st = SMB_IGNORE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_link_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            l_q     <= '0;
            l_q.scl <= SYNC_HIGH;
            l_q.sda <= SYNC_HIGH;
            l_q.cfg <= CFG_RESET;
        end else begin
            l_q <= l_d;
        end
    end

    // ****************
    // outputs
    // ****************
    assign o_sda         = 1'b0;
    assign o_sda_oe_n    = ~l_q.sda_drv;
    assign o_cfg         = l_q.cfg;
    assign o_conv_start  = c_q.conv_start;
    assign o_bus_timeout = c_q.to_pulse;

endmodule

// ==== testbench/sensor_smbus_sva.sv ====
// ****************************************
// bus front end checker
// ****************************************
module sensor_smbus_sva
    import sensor_smbus_pkg::*;
#(
    parameter int TIMEOUT_CYC = TIMEOUT_CYCLES
) (
    input wire logic    i_core_clk,    // core clock
    input wire logic    i_rst_n,       // reset
    input wire logic    i_link_clk,    // link clock
    input wire logic    i_scl,         // clock pin
    input wire logic    i_sda,         // data wire
    input wire logic    o_sda_oe_n,    // data enable
    input wire cfg_type o_cfg,         // settings
    input wire logic    o_conv_start,  // conversion pulse
    input wire logic    o_bus_timeout  // timeout pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    int   low_cnt_q;
    logic to_seen_q;
    // raw pins lead the filtered copies, so this count never trails the design's own
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            low_cnt_q <= 0;
            to_seen_q <= 1'b0;
        end else begin
            low_cnt_q <= (i_scl && i_sda) ? 0 : low_cnt_q + 1;
            to_seen_q <= !(i_scl && i_sda) && (to_seen_q || o_bus_timeout);
        end
    end
    property p_to_early; @(posedge i_core_clk) disable iff (!i_rst_n) o_bus_timeout |-> low_cnt_q >= TIMEOUT_CYC; endproperty
    a_to_early: assert property (p_to_early) else $error("timeout too early");
    property p_to_due; @(posedge i_core_clk) disable iff (!i_rst_n) low_cnt_q == TIMEOUT_CYC + 120 |-> to_seen_q; endproperty
    a_to_due: assert property (p_to_due) else $error("timeout missing");
    property p_to_pulse; @(posedge i_core_clk) disable iff (!i_rst_n) o_bus_timeout |=> !o_bus_timeout; endproperty
    a_to_pulse: assert property (p_to_pulse) else $error("timeout pulse too long");
    property p_to_free; @(posedge i_core_clk) disable iff (!i_rst_n) o_bus_timeout |-> ##[1:60] o_sda_oe_n; endproperty
    a_to_free: assert property (p_to_free) else $error("data not released");
    property p_oe_low; @(posedge i_link_clk) disable iff (!i_rst_n) $changed(o_sda_oe_n) |-> !i_scl; endproperty
    a_oe_low: assert property (p_oe_low) else $error("data moved with clock high");
    property p_cfg_low; @(posedge i_link_clk) disable iff (!i_rst_n) $changed(o_cfg) |-> !i_scl; endproperty
    a_cfg_low: assert property (p_cfg_low) else $error("settings moved with clock high");
    property p_start; @(posedge i_link_clk) disable iff (!i_rst_n) i_scl && $fell(i_sda) |-> o_sda_oe_n [*8]; endproperty
    a_start: assert property (p_start) else $error("drive after start");
    property p_conv; @(posedge i_core_clk) disable iff (!i_rst_n) o_conv_start |=> !o_conv_start; endproperty
    a_conv: assert property (p_conv) else $error("conversion pulse too long");
    c_conv: cover property (@(posedge i_core_clk) o_conv_start);
    c_to: cover property (@(posedge i_core_clk) o_bus_timeout);
    c_cfg: cover property (@(posedge i_link_clk) $changed(o_cfg));
endmodule

bind sensor_smbus_register_front sensor_smbus_sva #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_sva (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_link_clk(i_link_clk), .i_scl(i_scl), .i_sda(i_sda),
    .o_sda_oe_n(o_sda_oe_n), .o_cfg(o_cfg), .o_conv_start(o_conv_start), .o_bus_timeout(o_bus_timeout));

// ==== testbench/smbus_host_model.sv ====
// ****************************************
// bus host model
// ****************************************
module smbus_host_model
    import sensor_smbus_pkg::*;
#(
    parameter int HALF = 40
) (
    input  wire logic  i_clk,       // core clock
    input  wire logic  i_sda,       // data wire
    output logic       o_scl,       // clock pin
    output logic       o_sda_low,   // pulls data low
    output logic       o_rd_valid,  // read byte ready
    output logic [7:0] o_rd_data    // read byte
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
        o_rd_valid = 1'b0;
        o_rd_data = 8'h00;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // data moves an eighth of a period after the clock falls, to give hold time
    task automatic bit_io(input logic b, output logic r);
        tick(HALF / 4);
        o_sda_low <= !b;
        tick(HALF);
        o_scl <= 1'b1;
        tick(HALF);
        r = i_sda;
        o_scl <= 1'b0;
    endtask
    // start (a=1, b=0) or stop (a=0, b=1)
    task automatic cond(input logic a, input logic b);
        tick(HALF / 4);
        o_sda_low <= !a;
        tick(HALF);
        o_scl <= 1'b1;
        tick(HALF);
        o_sda_low <= !b;
        tick(HALF);
        o_scl <= b;
    endtask
    // start, then n bits of pat, every ninth left free for the ack
    task automatic part(input logic [23:0] pat, input int n);
        logic r;
        cond(1'b1, 1'b0);
        for (int i = 0; i < n; i++) begin
            bit_io((i % 9 == 8) ? 1'b1 : pat[23 - i / 9 * 8 - i % 9], r);
        end
        tick(HALF / 4);
        o_sda_low <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
        part({DEFAULT_SLAVE_ADDR, 1'b0, cmd, d}, 27);
        cond(1'b0, 1'b1);
    endtask
    task automatic rd(input logic [7:0] cmd, input int n);
        logic [7:0] v;
        logic       r;
        part({DEFAULT_SLAVE_ADDR, 1'b0, cmd, 8'h00}, 18);
        part({DEFAULT_SLAVE_ADDR, 1'b1, 16'h0000}, 9);
        for (int k = 0; k < n; k++) begin
            for (int i = 7; i >= 0; i--) begin
                bit_io(1'b1, v[i]);
            end
            bit_io(k == n - 1, r);
            o_rd_data <= v;
            o_rd_valid <= 1'b1;
            tick(1);
            o_rd_valid <= 1'b0;
        end
        cond(1'b0, 1'b1);
    endtask
endmodule

// ==== testbench/tb_top.sv ====
// ****************************************
// bench top
// ****************************************
module tb_top
    import sensor_smbus_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0;
    logic        link_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        scl;
    logic        sda_low;
    logic        sda_oe_n;
    logic        sda_out;
    logic        rd_valid;
    logic [7:0]  rd_data;
    logic        conv_start;
    logic        bus_timeout;
    meas_type    meas = '0;
    cfg_type     cfg;
    logic [16:0] lfsr = 17'h1085D;
    int          fail_count = 0;
    int          comparisons = 0;
    int          conv_cnt = 0;
    int          to_cnt = 0;
    logic [7:0]  exp_q[$];
    wire         sda = !sda_low && (sda_oe_n || sda_out);
    always #5 core_clk = ~core_clk;
    initial #13 forever #32 link_clk = ~link_clk;
    sensor_smbus_register_front #(.TIMEOUT_CYC(2000)) i_dut (
        .i_core_clk(core_clk), .i_rst_n(rst_n), .i_link_clk(link_clk), .i_scl(scl), .i_sda(sda),
        .o_sda(sda_out), .o_sda_oe_n(sda_oe_n), .i_meas(meas), .o_cfg(cfg), .o_conv_start(conv_start),
        .o_bus_timeout(bus_timeout));
    smbus_host_model i_host (.i_clk(core_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low),
        .o_rd_valid(rd_valid), .o_rd_data(rd_data));
    function automatic logic [7:0] rnd();
        repeat (8) lfsr = {lfsr[15:0], lfsr[16] ^ lfsr[13]};
        return lfsr[7:0];
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("mismatches=%0d comparisons=%0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic exp_rd(input logic [7:0] cmd, input logic [7:0] e);
        exp_q.push_back(e);
        i_host.rd(cmd, 1);
    endtask
    always @(posedge core_clk) begin
        conv_cnt <= conv_cnt + conv_start;
        to_cnt <= to_cnt + bus_timeout;
        if (rd_valid) begin
            chk(rd_data, exp_q.size() ? exp_q.pop_front() : 8'hXX);
        end
    end
    initial begin
        logic [7:0] d;
        logic [7:0] rv[7] = '{8'h00, 8'h08, 8'h46, 8'h69, 8'h00, 8'h00, 8'h00};
        logic [7:0] ca[7] = '{8'h09, 8'h0A, 8'h0B, 8'h0D, 8'h0E, 8'h0F, 8'h11};
        logic [7:0] base[5] = '{8'h03, 8'h04, 8'h05, 8'h07, 8'h08};
        repeat (16) @(posedge link_clk);
        @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (200) @(posedge core_clk);
        // unused locations 06 and 0C are never addressed
        for (int k = 0; k < 7; k++) begin
            exp_rd(ca[k], rv[k]);
        end
        for (int k = 0; k < 5; k++) begin
            d = rnd();
            i_host.wr(k[0] ? base[k] : base[k] + 8'h06, d);
            exp_rd(k[0] ? base[k] + 8'h06 : base[k], d);
        end
        for (int k = 0; k < 4; k++) begin
            d = rnd();
            @(posedge core_clk);
            meas <= '{rnd(), rnd(), d, rnd(), k[0], k[1]};
            repeat (100) @(posedge core_clk);
            exp_rd(8'h10, d & ((k != 0) ? 8'hF8 : 8'hE0));
        end
        d = rnd();
        i_host.wr(8'h11, d);
        exp_q.push_back(d);
        exp_q.push_back(d);
        i_host.rd(8'h11, 2);
        i_host.part({DEFAULT_SLAVE_ADDR, 1'b0, 8'h11, ~d}, 22);
        exp_rd(8'h11, d);
        i_host.wr(8'h0F, rnd());
        i_host.wr(8'h0F, 8'h00);
        repeat (20) @(posedge core_clk);
        chk(conv_cnt[7:0], 8'h02);
        chk(to_cnt[7:0], 8'h00);
        i_host.part({DEFAULT_SLAVE_ADDR, 1'b0, 16'h0000}, 8);
        for (int n = 0; n < 4000 && to_cnt == 0; n++) begin
            @(posedge core_clk);
        end
        repeat (60) @(posedge core_clk);
        chk({to_cnt[6:0], sda}, 8'h03);
        exp_rd(8'h11, d);
        repeat (50) @(posedge core_clk);
        chk(8'(exp_q.size()), 8'h00);
        test_done();
    end
    initial begin
        #2ms;
        fail_count++;
        test_done();
    end
endmodule
